//--- hw/cba_defs.vh
// Constants of the capture buffer access block.
// Assumes inclusion by bare name from each design file.
`ifndef CBA_DEFS_VH
`define CBA_DEFS_VH

// Command word layout: write flag, byte address, data byte
`define CBA_CMD_WR_BIT      15
`define CBA_CMD_ADDR_HI     14
`define CBA_CMD_ADDR_LO     8
`define CBA_CMD_DATA_HI     7
`define CBA_CMD_DATA_LO     0

// Byte addresses, low byte of each register first
`define CBA_ADDR_IDX_LO     7'h0A
`define CBA_ADDR_IDX_HI     7'h0B
`define CBA_ADDR_REC_LO     7'h0C
`define CBA_ADDR_REC_HI     7'h0D
`define CBA_ADDR_X_LO       7'h0E
`define CBA_ADDR_X_HI       7'h0F
`define CBA_ADDR_Y_LO       7'h10
`define CBA_ADDR_Y_HI       7'h11
`define CBA_ADDR_Z_LO       7'h12
`define CBA_ADDR_Z_HI       7'h13

// Mode field encodings
`define CBA_MODE_MANUAL_SPEC 2'h0
`define CBA_MODE_AUTO_SPEC   2'h1
`define CBA_MODE_TIME_CAP    2'h2
`define CBA_MODE_STREAM      2'h3

// Sample index limits and widths
`define CBA_IDX_W            12
`define CBA_IDX_MAX_SPEC     12'h7FF
`define CBA_IDX_MAX_TIME     12'hFFF
`define CBA_IDX_ZERO         12'h000
`define CBA_BUF_DEPTH        4096

// Record numbers
`define CBA_SPEC_REC_MAX     4'h9
`define CBA_SPEC_REC_W       4
`define CBA_STAT_REC_W       5

// Register reset and default values
`define CBA_REG_RESET        16'h0000
`define CBA_X_CAPTURE_DEF    16'h8000
`define CBA_BYTE_ZERO        8'h00

`endif

//--- hw/cba_fifo2.v
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module cba_fifo2 #(
  parameter W = 16
) (
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire         i_in_valid,
  output wire         o_in_ready,
  input  wire [W-1:0] i_in_data,
  output wire         o_out_valid,
  input  wire         i_out_ready,
  output wire [W-1:0] o_out_data
);

  reg [W-1:0] ent0_q;
  reg [W-1:0] ent1_q;
  reg [1:0]   cnt_q;
  wire        push;
  wire        pop;

  assign o_in_ready  = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_data  = ent0_q;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // Entry 0 is always the head
  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q  <= 2'h0;
      ent0_q <= {W{1'b0}};
      ent1_q <= {W{1'b0}};
    end else begin
      if (push & ~pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 2'h1;
      if (pop) begin
        if (cnt_q == 2'h2)
          ent0_q <= ent1_q;
        else if (push)
          ent0_q <= i_in_data;
        if (push & (cnt_q == 2'h2))
          ent1_q <= i_in_data;
      end else if (push) begin
        if (cnt_q == 2'h0)
          ent0_q <= i_in_data;
        else
          ent1_q <= i_in_data;
      end
    end
  end

endmodule // cba_fifo2

//--- hw/cba_index.v
// Sample index counter: byte writes, auto-advance, mode wrap.
// Assumes one clock and a synchronous active-high reset.
`include "cba_defs.vh"
module cba_index (
  input  wire                  i_clk,
  input  wire                  i_rst,
  input  wire                  i_clear,
  input  wire                  i_wr_lo,
  input  wire                  i_wr_hi,
  input  wire [7:0]            i_wdata,
  input  wire                  i_adv,
  input  wire [1:0]            i_mode,
  output wire [`CBA_IDX_W-1:0] o_index,
  output reg                   o_load
);

  reg [`CBA_IDX_W-1:0] idx_q;
  reg [`CBA_IDX_W-1:0] idx_d;
  reg                  load_d;

  function [`CBA_IDX_W-1:0] idx_max;
    input [1:0] mode;
    begin
      if (mode == `CBA_MODE_TIME_CAP)
        idx_max = `CBA_IDX_MAX_TIME;
      else
        idx_max = `CBA_IDX_MAX_SPEC;
    end
  endfunction

  assign o_index = idx_q;

  // Capture end wins, then host write, then advance
  always @* begin
    idx_d  = idx_q;
    load_d = 1'b0;
    if (i_clear) begin
      idx_d  = `CBA_IDX_ZERO;
      load_d = 1'b1;
    end else if (i_wr_lo) begin
      idx_d = {idx_q[`CBA_IDX_W-1:8], i_wdata};
    end else if (i_wr_hi) begin
      // Top four bits of the byte are kept zero by the host
      idx_d  = {i_wdata[3:0], idx_q[7:0]};
      load_d = 1'b1;
    end else if (i_adv) begin
      if (idx_q >= idx_max(i_mode))
        idx_d = `CBA_IDX_ZERO;
      else
        idx_d = idx_q + 12'h001;
      load_d = 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      idx_q  <= `CBA_IDX_ZERO;
      o_load <= 1'b0;
    end else begin
      idx_q  <= idx_d;
      o_load <= load_d;
    end
  end

endmodule // cba_index

//--- hw/cba_capture_buffer_access.v
// Register side of the stored capture buffers: sample index,
// record select and the three axis data registers.
// Assumes word-level commands from a serial front end, and a
// capture engine that fills the buffers and signals start/end.
`include "cba_defs.vh"

// Function
// - Capture end clears sample index to zero
// - Axis data read advances sample index, except in streaming mode
// - Index wraps to zero after mode maximum
// - Index is 12 bits, depth set by mode
// - Index high byte write loads that sample into axes
// - Spectral record 0..9 load, spectral modes
// - Statistics record 0..31 load request
// - X register shows buffer entry at index
// - Streaming mode bypasses register data buffers
// - Full axis read loads next sample, advances
// - X shows 0x8000 from first capture start
// - Time capture data: signed 16-bit samples
// - Velocity enable stores velocity instead
// - Spectral modes: unsigned 16-bit bin values
// - Magnitude enable puts combined magnitude in z
module cba_capture_buffer_access (
  input  wire                  i_clk,
  input  wire                  i_rst,
  // Register command port
  input  wire                  i_cmd_valid,
  output wire                  o_cmd_ready,
  input  wire [15:0]           i_cmd,
  output wire                  o_rd_valid,
  input  wire                  i_rd_ready,
  output wire [15:0]           o_rd_data,
  // Capture control bits
  input  wire [1:0]            i_mode,
  input  wire                  i_velocity_en,
  input  wire                  i_magnitude_en,
  // Capture engine side
  input  wire                  i_cap_start,
  input  wire                  i_cap_done,
  input  wire                  i_cap_wr,
  input  wire [`CBA_IDX_W-1:0] i_cap_addr,
  input  wire [15:0]           i_cap_acc_x,
  input  wire [15:0]           i_cap_acc_y,
  input  wire [15:0]           i_cap_acc_z,
  input  wire [15:0]           i_cap_vel_x,
  input  wire [15:0]           i_cap_vel_y,
  input  wire [15:0]           i_cap_vel_z,
  input  wire [15:0]           i_cap_mag,
  // Record loader requests
  output reg                   o_spec_load,
  output reg  [3:0]            o_spec_rec,
  output reg                   o_stat_load,
  output reg  [4:0]            o_stat_rec,
  output wire [`CBA_IDX_W-1:0] o_index
);

  //////////////////////////////////////////////////////////////////////
  // Buffers and registers

  reg  [15:0] buf_x [0:`CBA_BUF_DEPTH-1];
  reg  [15:0] buf_y [0:`CBA_BUF_DEPTH-1];
  reg  [15:0] buf_z [0:`CBA_BUF_DEPTH-1];

  reg  [15:0] x_q;
  reg  [15:0] y_q;
  reg  [15:0] z_q;
  reg  [15:0] rec_q;
  reg  [15:0] rsp_d;
  reg         first_q;

  wire        take;
  wire        is_wr;
  wire [6:0]  addr;
  wire [7:0]  wdata;
  wire [6:0]  word_addr;
  wire        rd_ready;
  wire        streaming;
  wire        spectral;
  wire        axis_rd;
  wire        idx_load;
  wire [`CBA_IDX_W-1:0] idx;
  wire        rd_take;
  wire        rd_req;
  wire        wr_idx_lo;
  wire        wr_idx_hi;
  wire        wr_rec_lo;
  wire        wr_rec_hi;
  wire        spec_ok;
  wire        cap_fill;
  wire [15:0] fill_x;
  wire [15:0] fill_y;
  wire [15:0] fill_z;
  wire [15:0] at_x;
  wire [15:0] at_y;
  wire [15:0] at_z;
  reg  [15:0] x_d;
  reg  [15:0] y_d;
  reg  [15:0] z_d;
  reg         first_d;
  reg  [15:0] rec_d;
  reg         spec_load_d;
  reg  [3:0]  spec_rec_d;
  reg         stat_load_d;
  reg  [4:0]  stat_rec_d;

  //////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Host write to one byte address
  function wr_hit;
    input       valid;
    input       wr;
    input [6:0] a;
    input [6:0] target;
    begin
      wr_hit = valid & wr & (a == target);
    end
  endfunction

  // Word address of an axis data register
  function is_axis;
    input [6:0] wa;
    begin
      is_axis = (wa == `CBA_ADDR_X_LO) |
                (wa == `CBA_ADDR_Y_LO) |
                (wa == `CBA_ADDR_Z_LO);
    end
  endfunction

  // Velocity or acceleration word for a buffer
  function [15:0] pick;
    input        vel_en;
    input [15:0] acc;
    input [15:0] vel;
    begin
      pick = vel_en ? vel : acc;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Command decode

  assign is_wr     = i_cmd[`CBA_CMD_WR_BIT];
  assign addr      = i_cmd[`CBA_CMD_ADDR_HI:`CBA_CMD_ADDR_LO];
  assign wdata     = i_cmd[`CBA_CMD_DATA_HI:`CBA_CMD_DATA_LO];
  assign word_addr = {addr[6:1], 1'b0};
  assign take      = i_cmd_valid & rd_ready;
  assign o_cmd_ready = rd_ready;
  assign o_index   = idx;

  assign streaming = (i_mode == `CBA_MODE_STREAM);
  assign spectral  = (i_mode == `CBA_MODE_MANUAL_SPEC) |
                     (i_mode == `CBA_MODE_AUTO_SPEC);

  // One word read of an axis register covers both bytes
  assign rd_req  = i_cmd_valid & ~is_wr;
  assign rd_take = take & ~is_wr;
  assign axis_rd = rd_take & ~streaming & is_axis(word_addr);

  assign wr_idx_lo = wr_hit(take, is_wr, addr, `CBA_ADDR_IDX_LO);
  assign wr_idx_hi = wr_hit(take, is_wr, addr, `CBA_ADDR_IDX_HI);
  assign wr_rec_lo = wr_hit(take, is_wr, addr, `CBA_ADDR_REC_LO);
  assign wr_rec_hi = wr_hit(take, is_wr, addr, `CBA_ADDR_REC_HI);
  assign spec_ok   = spectral &
                     (wdata[`CBA_SPEC_REC_W-1:0] <= `CBA_SPEC_REC_MAX);

  //////////////////////////////////////////////////////////////////////
  // Sample index

  cba_index u_index (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_clear (i_cap_done),
    .i_wr_lo (wr_idx_lo),
    .i_wr_hi (wr_idx_hi),
    .i_wdata (wdata),
    .i_adv   (axis_rd),
    .i_mode  (i_mode),
    .o_index (idx),
    .o_load  (idx_load)
  );

  //////////////////////////////////////////////////////////////////////
  // Buffer fill from the capture engine

  // Data formats pass through unchanged: signed in time capture,
  // unsigned bins in the spectral modes
  assign cap_fill = i_cap_wr & ~streaming;
  assign fill_x   = pick(i_velocity_en, i_cap_acc_x, i_cap_vel_x);
  assign fill_y   = pick(i_velocity_en, i_cap_acc_y, i_cap_vel_y);
  assign fill_z   = i_magnitude_en ? i_cap_mag
                  : pick(i_velocity_en, i_cap_acc_z, i_cap_vel_z);

  always @(posedge i_clk) begin
    if (cap_fill) begin
      buf_x[i_cap_addr] <= fill_x;
      buf_y[i_cap_addr] <= fill_y;
      buf_z[i_cap_addr] <= fill_z;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Axis data registers

  assign at_x = buf_x[idx];
  assign at_y = buf_y[idx];
  assign at_z = buf_z[idx];

  // Index load beats the capture-start default
  always @* begin
    x_d     = x_q;
    y_d     = y_q;
    z_d     = z_q;
    first_d = first_q | i_cap_start;
    if (idx_load & ~streaming) begin
      x_d = at_x;
      y_d = at_y;
      z_d = at_z;
    end else if (i_cap_start & ~first_q) begin
      x_d = `CBA_X_CAPTURE_DEF;
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      x_q     <= `CBA_REG_RESET;
      y_q     <= `CBA_REG_RESET;
      z_q     <= `CBA_REG_RESET;
      first_q <= 1'b0;
    end else begin
      x_q     <= x_d;
      y_q     <= y_d;
      z_q     <= z_d;
      first_q <= first_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Record select

  // Load pulses last one cycle; record numbers stay
  always @* begin
    rec_d       = rec_q;
    spec_load_d = 1'b0;
    spec_rec_d  = o_spec_rec;
    stat_load_d = 1'b0;
    stat_rec_d  = o_stat_rec;
    if (wr_rec_lo) begin
      // Bits 7:4 arrive as zero from the host
      rec_d[7:0] = wdata;
      if (spec_ok) begin
        spec_load_d = 1'b1;
        spec_rec_d  = wdata[`CBA_SPEC_REC_W-1:0];
      end
    end
    if (wr_rec_hi) begin
      rec_d[15:8] = wdata;
      stat_load_d = 1'b1;
      stat_rec_d  = wdata[`CBA_STAT_REC_W-1:0];
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      rec_q       <= `CBA_REG_RESET;
      o_spec_load <= 1'b0;
      o_spec_rec  <= 4'h0;
      o_stat_load <= 1'b0;
      o_stat_rec  <= 5'h00;
    end else begin
      rec_q       <= rec_d;
      o_spec_load <= spec_load_d;
      o_spec_rec  <= spec_rec_d;
      o_stat_load <= stat_load_d;
      o_stat_rec  <= stat_rec_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read answers

  always @* begin
    case (word_addr)
      `CBA_ADDR_IDX_LO: rsp_d = {4'h0, idx};
      `CBA_ADDR_REC_LO: rsp_d = rec_q;
      `CBA_ADDR_X_LO:   rsp_d = x_q;
      `CBA_ADDR_Y_LO:   rsp_d = y_q;
      `CBA_ADDR_Z_LO:   rsp_d = z_q;
      default:          rsp_d = `CBA_REG_RESET;
    endcase
  end

  // Stall on a full answer buffer loses no word
  cba_fifo2 #(
    .W (16)
  ) u_rsp (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (rd_req),
    .o_in_ready  (rd_ready),
    .i_in_data   (rsp_d),
    .o_out_valid (o_rd_valid),
    .i_out_ready (i_rd_ready),
    .o_out_data  (o_rd_data)
  );

endmodule // cba_capture_buffer_access

//--- verification/cba_host_model.sv
// Host side model: takes answer words, can stall.
// Assumes the block's answer port and one clock.
module cba_host_model (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_stall,
  input  wire        i_rd_valid,
  input  wire [15:0] i_rd_data,
  output wire        o_rd_ready,
  output reg  [15:0] o_last,
  output reg  [7:0]  o_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_rd_ready = !i_stall;
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_cnt  <= 8'h00;
      o_last <= 16'h0000;
    end else if (i_rd_valid && o_rd_ready) begin
      o_cnt  <= o_cnt + 8'h01;
      o_last <= i_rd_data;
    end
  end
endmodule // cba_host_model

//--- verification/cba_asserts.sv
// Checker of the capture buffer access ports.
// Assumes one clock, sync active-high reset.
module cba_asserts (
  input wire        i_clk,
  input wire        i_rst,
  input wire        i_cmd_valid,
  input wire        o_cmd_ready,
  input wire [15:0] i_cmd,
  input wire [1:0]  i_mode,
  input wire        i_cap_done,
  input wire        o_spec_load,
  input wire [3:0]  o_spec_rec,
  input wire        o_stat_load,
  input wire [4:0]  o_stat_rec,
  input wire [11:0] o_index
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire        tk = i_cmd_valid && o_cmd_ready;
  wire [6:0]  ad = i_cmd[14:8];
  wire        wr = tk && i_cmd[15];
  wire        rd = tk && !i_cmd[15] && !i_cap_done;
  wire        ax = rd && ad >= 7'h0E && ad <= 7'h13 && i_mode != 2'h3;
  wire [11:0] mx = (i_mode == 2'h2) ? 12'hFFF : 12'h7FF;
  wire        sw = wr && ad == 7'h0C;
  //////////////////////////////////////////////////////////////////////
  chk_done_clear: assert property (i_cap_done |=> o_index == 12'h000)
    else $error("index not cleared at capture end");
  chk_read_adv: assert property (ax && o_index < mx
    |=> o_index == $past(o_index) + 12'h001) else $error("no advance");
  chk_read_wrap: assert property (ax && o_index >= mx |=> !o_index)
    else $error("index did not wrap");
  chk_stream_hold: assert property (rd && i_mode == 2'h3 |=> $stable(o_index))
    else $error("index moved in streaming");
  chk_idx_write: assert property (wr && ad == 7'h0B && !i_cap_done
    |=> o_index[11:8] == $past(i_cmd[3:0])) else $error("index high");
  chk_spec_load: assert property (sw && !i_mode[1] && i_cmd[7:0] <= 8'h09
    |=> o_spec_load && o_spec_rec == $past(i_cmd[3:0]))
    else $error("spectral load missing");
  chk_spec_gate: assert property (sw && (i_mode[1] || i_cmd[7:0] > 8'h09)
    |=> !o_spec_load) else $error("spectral load not gated");
  chk_stat_load: assert property (wr && ad == 7'h0D
    |=> o_stat_load && o_stat_rec == $past(i_cmd[4:0]))
    else $error("statistics load missing");
  cover property (ax && o_index >= mx);
  cover property (o_spec_load);
  cover property (o_stat_load);
endmodule // cba_asserts
bind cba_capture_buffer_access cba_asserts u_chk (.i_clk, .i_rst,
  .i_cmd_valid, .o_cmd_ready, .i_cmd, .i_mode, .i_cap_done, .o_spec_load,
  .o_spec_rec, .o_stat_load, .o_stat_rec, .o_index);

//--- verification/testbench.sv
// Self-checking bench of the capture buffer access block.
// Assumes host model and checker compiled first.
`define CHK(g, e, n) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_rst, i_cmd_valid, i_cap_start, i_cap_done, i_cap_wr;
  logic        i_velocity_en, i_magnitude_en, stall;
  logic [1:0]  i_mode;
  logic [15:0] i_cmd;
  logic [11:0] i_cap_addr;
  logic [3:0]  spec_rec;
  logic [4:0]  stat_rec;
  wire         o_cmd_ready, o_rd_valid, i_rd_ready, o_spec_load, o_stat_load;
  wire  [15:0] o_rd_data, last;
  wire  [3:0]  o_spec_rec;
  wire  [4:0]  o_stat_rec;
  wire  [11:0] o_index;
  wire  [7:0]  cnt;
  int          n_errors = 0, checked = 0, cyc = 0, n_spec = 0, n_stat = 0;
  cba_capture_buffer_access i_dut (.i_clk, .i_rst, .i_cmd_valid,
    .o_cmd_ready, .i_cmd, .o_rd_valid, .i_rd_ready, .o_rd_data, .i_mode,
    .i_velocity_en, .i_magnitude_en, .i_cap_start, .i_cap_done, .i_cap_wr,
    .i_cap_addr, .i_cap_acc_x({4'hA, i_cap_addr}),
    .i_cap_acc_y({4'hB, i_cap_addr}), .i_cap_acc_z({4'hC, i_cap_addr}),
    .i_cap_vel_x({4'h1, i_cap_addr}), .i_cap_vel_y({4'h2, i_cap_addr}),
    .i_cap_vel_z({4'h3, i_cap_addr}), .i_cap_mag({4'hD, i_cap_addr}),
    .o_spec_load, .o_spec_rec, .o_stat_load, .o_stat_rec, .o_index);
  cba_host_model i_host (.i_clk, .i_rst, .i_stall(stall),
    .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data), .o_rd_ready(i_rd_ready),
    .o_last(last), .o_cnt(cnt));
  //////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmd(input logic [15:0] w);
    int k;
    k = 0;
    i_cmd = w;
    i_cmd_valid = 1'b1;
    @(negedge i_clk);
    while (o_cmd_ready !== 1'b1 && k < 50) begin
      @(negedge i_clk);
      k++;
    end
    `CHK(o_cmd_ready, 1'b1, "command ready")
    @(posedge i_clk);
    #1 i_cmd_valid = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e, string n);
    logic [7:0] c0;
    int k;
    c0 = cnt;
    k = 0;
    cmd({1'b0, a, 8'h00});
    while (cnt === c0 && k < 50) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    `CHK(cnt !== c0, 1'b1, n)
    `CHK(last, e, n)
  endtask
  task automatic wr16(input logic [15:0] v);
    cmd({8'h8A, v[7:0]});
    cmd({8'h8B, 4'h0, v[11:8]});
  endtask
  task automatic cap(input logic [11:0] a);
    i_cap_addr = a;
    i_cap_wr = 1'b1;
    @(posedge i_clk);
    #1 i_cap_wr = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (o_spec_load === 1'b1) begin
      n_spec++;
      spec_rec = o_spec_rec;
    end
    if (o_stat_load === 1'b1) begin
      n_stat++;
      stat_rec = o_stat_rec;
    end
    if (cyc == 5000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    logic [7:0] c0;
    int k;
    {i_rst, i_cmd_valid, i_cap_start, i_cap_done, i_cap_wr} = 5'h10;
    {i_velocity_en, i_magnitude_en, stall} = 3'h0;
    i_mode = 2'h2;
    i_cmd = 16'h0000;
    i_cap_addr = 12'h000;
    repeat (12) @(posedge i_clk);
    #1 i_rst = 1'b0;
    rd(7'h0A, 16'h0000, "index reset");
    rd(7'h0C, 16'h0000, "record reset");
    rd(7'h20, 16'h0000, "unmapped read");
    i_cap_start = 1'b1;
    @(posedge i_clk);
    #1 i_cap_start = 1'b0;
    rd(7'h0E, 16'h8000, "x default");
    $display("reset test done");
    cap(12'h000);
    cap(12'h001);
    cap(12'h002);
    cap(12'h7FF);
    cap(12'hFFF);
    i_cap_done = 1'b1;
    @(posedge i_clk);
    #1 i_cap_done = 1'b0;
    rd(7'h0A, 16'h0000, "index cleared");
    rd(7'h0E, 16'hA000, "x entry 0");
    rd(7'h10, 16'hB001, "y entry 1");
    rd(7'h13, 16'hC002, "z entry 2");
    rd(7'h0A, 16'h0003, "index after reads");
    wr16(16'h0FFF);
    rd(7'h0E, 16'hAFFF, "x at 4095");
    rd(7'h0A, 16'h0000, "time wrap");
    for (int m = 0; m < 2; m++) begin
      i_mode = m[1:0];
      wr16(16'h07FF);
      rd(7'h0E, 16'hA7FF, "x at 2047");
      rd(7'h0A, 16'h0000, "spectral wrap");
    end
    $display("index test done");
    {i_velocity_en, i_magnitude_en} = 2'b11;
    cap(12'h005);
    wr16(16'h0005);
    rd(7'h12, 16'hD005, "magnitude in z");
    wr16(16'h0005);
    rd(7'h0E, 16'h1005, "velocity x");
    {i_velocity_en, i_magnitude_en} = 2'b00;
    wr16(16'h0005);
    i_mode = 2'h3;
    rd(7'h0E, 16'h1005, "stream x");
    rd(7'h0A, 16'h0005, "stream index");
    $display("format test done");
    i_mode = 2'h0;
    cmd(16'h8C0A);
    cmd(16'h8C03);
    cmd(16'h8D15);
    i_mode = 2'h2;
    cmd(16'h8C04);
    `CHK(n_spec, 1, "spectral loads")
    `CHK(spec_rec, 4'h3, "spectral record")
    `CHK(n_stat, 1, "statistics loads")
    `CHK(stat_rec, 5'h15, "statistics record")
    rd(7'h0C, 16'h1504, "record register");
    $display("record test done");
    stall = 1'b1;
    c0 = cnt;
    cmd(16'h0A00);
    cmd(16'h0A00);
    @(negedge i_clk);
    `CHK(o_cmd_ready, 1'b0, "full refuses")
    stall = 1'b0;
    k = 0;
    while (cnt !== c0 + 8'h02 && k < 50) begin
      @(posedge i_clk);
      k++;
    end
    `CHK(last, 16'h0005, "drained word")
    $display("buffer test done");
    conclude();
  end
endmodule // testbench
